// file: hdl/uart_int_pkg.sv
// shared constants for the uart interrupt and fifo control block
package uart_int_pkg;
    // register addresses on the three-bit bus
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_INT_MASK = 3'h1;
    localparam logic [2:0] ADDR_SRC_FCTL = 3'h2;
    localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
    localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
    // interrupt mask bit positions
    localparam int MASK_RX_DATA = 0;
    localparam int MASK_TX_READY = 1;
    localparam int MASK_LINE = 2;
    localparam int MASK_MODEM = 3;
    localparam int MASK_ENH_LO = 4;
    localparam int MASK_XOFF = 5;
    localparam int MASK_RTS = 6;
    localparam int MASK_CTS = 7;
    localparam logic [7:0] INT_MASK_RESET = 8'h00;
    // fifo control bit positions
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_RESET = 1;
    localparam int FC_TX_RESET = 2;
    localparam int FC_DMA = 3;
    localparam int FC_TX_TRIG_LO = 4;
    localparam int FC_RX_TRIG_LO = 6;
    // interrupt source codes, bits 5:0
    localparam logic [5:0] SRC_LINE = 6'h06;
    localparam logic [5:0] SRC_TIMEOUT = 6'h0C;
    localparam logic [5:0] SRC_RX_DATA = 6'h04;
    localparam logic [5:0] SRC_TX_READY = 6'h02;
    localparam logic [5:0] SRC_MODEM = 6'h00;
    localparam logic [5:0] SRC_XOFF_SPECIAL = 6'h10;
    localparam logic [5:0] SRC_FLOW_PIN = 6'h20;
    localparam logic [5:0] SRC_NONE = 6'h01;
    localparam logic [1:0] FIFO_ON_BITS = 2'h3;
    // trigger levels for select codes 00..11
    localparam logic [4:0] TRIG_LVL_0 = 5'h01;
    localparam logic [4:0] TRIG_LVL_1 = 5'h04;
    localparam logic [4:0] TRIG_LVL_2 = 5'h08;
    localparam logic [4:0] TRIG_LVL_3 = 5'h0E;
    // receive timeout: four characters plus twelve bit times
    localparam logic [3:0] TIMEOUT_CHARS = 4'h4;
    localparam logic [7:0] TIMEOUT_EXTRA_BITS = 8'h0C;
    localparam int FIFO_DEPTH = 16;
    localparam int COUNT_W = 5;

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'h0: trig_level = TRIG_LVL_0;
            2'h1: trig_level = TRIG_LVL_1;
            2'h2: trig_level = TRIG_LVL_2;
            default: trig_level = TRIG_LVL_3;
        endcase
    endfunction
endpackage

// file: hdl/int_priority_enc.sv
// priority encoder for the pending interrupt sources
`timescale 1ns/1ps
`default_nettype none
module int_priority_enc (
    input wire logic line_in,
    input wire logic timeout_in,
    input wire logic rx_data_in,
    input wire logic tx_ready_in,
    input wire logic modem_in,
    input wire logic xoff_special_in,
    input wire logic flow_pin_in,
    output logic [5:0] code_out
);
    import uart_int_pkg::*;
    // only the highest pending level is reported; the rest wait their turn
    // codes of levels one to three
    // codes of levels four to seven
    always_comb begin
        if (line_in) begin
            code_out = SRC_LINE;
        end else if (timeout_in) begin
            code_out = SRC_TIMEOUT;
        end else if (rx_data_in) begin
            code_out = SRC_RX_DATA;
        end else if (tx_ready_in) begin
            code_out = SRC_TX_READY;
        end else if (modem_in) begin
            code_out = SRC_MODEM;
        end else if (xoff_special_in) begin
            code_out = SRC_XOFF_SPECIAL;
        end else if (flow_pin_in) begin
            code_out = SRC_FLOW_PIN;
        end else begin
            code_out = SRC_NONE;
        end
    end
endmodule // int_priority_enc
`default_nettype wire

// file: hdl/rx_timeout_timer.sv
// receive timeout timer counted in bit times
`timescale 1ns/1ps
`default_nettype none
module rx_timeout_timer (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic run_in,
    input wire logic restart_in,
    input wire logic bit_tick_in,
    input wire logic [3:0] char_bits_in,
    output logic expire_out
);
    import uart_int_pkg::*;
    logic [7:0] count_ff;
    wire [7:0] limit = 8'({4'h0, char_bits_in} * {4'h0, TIMEOUT_CHARS}) + TIMEOUT_EXTRA_BITS;
    wire at_limit = (count_ff == limit);
    assign expire_out = run_in && bit_tick_in && (count_ff == limit - 8'h01);
    // the timer holds at the limit so the event fires once per idle gap
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count_ff <= 8'h00;
        end else if (ce_in) begin
            if (restart_in || !run_in) begin
                count_ff <= 8'h00;
            end else if (bit_tick_in && !at_limit) begin
                count_ff <= count_ff + 8'h01;
            end
        end
    end
endmodule // rx_timeout_timer
`default_nettype wire

// file: hdl/uart_interrupt_fifo_control.sv
// interrupt prioritisation and fifo control for one uart channel
//
// Overview of operation
// - mask bit 5 enables receive xoff interrupt; default off; enhanced mode only.
// - mask bit 6 set: interrupt on request-to-send rising edge.
// - mask bit 7 set: interrupt on clear-to-send rising edge.
// - source read returns highest pending code; lower ones wait.
// - codes: line status 000110, timeout 001100, receive data 000100.
// - codes: tx 000010, modem 000000, xoff 010000, pin 100000, none 000001.
// - line status interrupt from status bits 1-4; cleared by line status read.
// - receive data interrupt while fifo level is at or above trigger.
// - receive timeout after four characters plus twelve bits; cleared by data read.
// - tx ready on trigger or empty; cleared by source read or data write.
// - modem interrupt from modem bits 0-3; cleared by modem status read.
// - xoff interrupt on match; cleared by source read or xon.
// - special character interrupt; cleared by source read or next character.
// - flow pin rising edges interrupt; cleared by modem status read; bit 5.
// - wake-up indication reads as no-interrupt code; cleared by source read.
// - source bit 0 low while pending, high otherwise.
// - source bits 7:6 both high while fifos are enabled.
// - fifo control bit 0 enables fifos; other bits need it in same write.
// - bit 1 resets receive fifo pointers, self clearing.
// - bit 2 resets transmit fifo pointers, self clearing.
// - bit 3 selects dma mode for the ready pins.
// - bits 5:4 select tx trigger in enhanced mode; last selection applies both.
// - trigger codes 00..11 give 1, 4, 8 and 14 characters.
`timescale 1ns/1ps
`default_nettype none
module uart_interrupt_fifo_control #(
    parameter int DEPTH = uart_int_pkg::FIFO_DEPTH
) (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic CE_IN,
    input wire logic [2:0] ADDR_IN,
    input wire logic RD_STROBE_IN,
    input wire logic WR_STROBE_IN,
    input wire logic [7:0] WR_DATA_IN,
    input wire logic ENH_ENABLE_IN,
    input wire logic [4:1] LINE_STATUS_IN,
    input wire logic [3:0] MODEM_STATUS_IN,
    input wire logic [uart_int_pkg::COUNT_W-1:0] RX_COUNT_IN,
    input wire logic [uart_int_pkg::COUNT_W-1:0] TX_COUNT_IN,
    input wire logic RX_CHAR_IN,
    input wire logic BIT_TICK_IN,
    input wire logic [3:0] CHAR_BITS_IN,
    input wire logic XOFF_MATCH_IN,
    input wire logic XON_MATCH_IN,
    input wire logic SPECIAL_MATCH_IN,
    input wire logic CTS_IN,
    input wire logic RTS_IN,
    input wire logic SLEEP_EXIT_IN,
    output logic [7:0] RD_DATA_OUT,
    output logic INT_OUT,
    output logic FIFO_EN_OUT,
    output logic RX_FIFO_RESET_OUT,
    output logic TX_FIFO_RESET_OUT,
    output logic DMA_MODE_OUT,
    output logic [4:0] TRIG_LEVEL_OUT,
    output logic SLEEP_EN_OUT,
    output logic RX_DMA_REQUEST_N_OUT,
    output logic TX_DMA_REQUEST_N_OUT
);
    import uart_int_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] mask_ff;
    logic fifo_en_ff;
    logic dma_ff;
    logic [1:0] trig_sel_ff;
    logic tx_flag_ff;
    logic tx_above_ff;
    logic [COUNT_W-1:0] tx_count_d_ff;
    logic timeout_flag_ff;
    logic xoff_flag_ff;
    logic special_flag_ff;
    logic cts_flag_ff;
    logic rts_flag_ff;
    logic cts_d_ff;
    logic rts_d_ff;
    logic wake_ff;
    logic [5:0] code;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire wr_data = WR_STROBE_IN && (ADDR_IN == ADDR_DATA);
    wire rd_data = RD_STROBE_IN && (ADDR_IN == ADDR_DATA);
    wire wr_mask = WR_STROBE_IN && (ADDR_IN == ADDR_INT_MASK);
    wire rd_mask = RD_STROBE_IN && (ADDR_IN == ADDR_INT_MASK);
    wire wr_fctl = WR_STROBE_IN && (ADDR_IN == ADDR_SRC_FCTL);
    wire rd_src = RD_STROBE_IN && (ADDR_IN == ADDR_SRC_FCTL);
    wire rd_line = RD_STROBE_IN && (ADDR_IN == ADDR_LINE_STATUS);
    wire rd_modem = RD_STROBE_IN && (ADDR_IN == ADDR_MODEM_STATUS);

    // upper mask bits only writable in enhanced mode
    wire [7:0] nxt_mask = ENH_ENABLE_IN ? WR_DATA_IN :
                          {mask_ff[MASK_CTS:MASK_ENH_LO], WR_DATA_IN[MASK_MODEM:0]};

    // a write with the enable bit clear programs nothing else
    wire fc_take = wr_fctl && WR_DATA_IN[FC_ENABLE];
    // enhanced writes take the tx select, which then serves both sides
    wire [1:0] nxt_trig_sel = ENH_ENABLE_IN ? WR_DATA_IN[FC_TX_TRIG_LO +: 2] :
                              WR_DATA_IN[FC_RX_TRIG_LO +: 2];
    wire [COUNT_W-1:0] trig = trig_level(trig_sel_ff);

    // ----------------------------------------------------------------
    // source conditions
    // ----------------------------------------------------------------
    // line status level, clears when the status bits are read away
    wire line_pend = mask_ff[MASK_LINE] && (|LINE_STATUS_IN);
    // level follows the fifo count against the trigger
    wire rx_level = fifo_en_ff ? (RX_COUNT_IN >= trig) : (RX_COUNT_IN != '0);
    wire rx_pend = mask_ff[MASK_RX_DATA] && rx_level;
    wire to_pend = mask_ff[MASK_RX_DATA] && timeout_flag_ff;
    wire tx_pend = mask_ff[MASK_TX_READY] && tx_flag_ff;
    wire modem_pend = mask_ff[MASK_MODEM] && (|MODEM_STATUS_IN);
    wire xs_pend = ENH_ENABLE_IN && mask_ff[MASK_XOFF] && (xoff_flag_ff || special_flag_ff);
    wire flow_pend = ENH_ENABLE_IN && (cts_flag_ff || rts_flag_ff);
    // low bit reads high with nothing pending
    wire any_pend = (code != SRC_NONE);

    // priority encoder picks the single reported source
    int_priority_enc u_enc (
        .line_in(line_pend),
        .timeout_in(to_pend),
        .rx_data_in(rx_pend),
        .tx_ready_in(tx_pend),
        .modem_in(modem_pend),
        .xoff_special_in(xs_pend),
        .flow_pin_in(flow_pend),
        .code_out(code)
    );

    // timer restarts on each new character or data read
    wire to_expire;
    rx_timeout_timer u_timer (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .ce_in(CE_IN),
        .run_in(fifo_en_ff && (RX_COUNT_IN != '0)),
        .restart_in(RX_CHAR_IN || rd_data),
        .bit_tick_in(BIT_TICK_IN),
        .char_bits_in(CHAR_BITS_IN),
        .expire_out(to_expire)
    );

    // source-read clears of tx ready and xoff/special act only on the source actually reported
    wire src_rd_tx = rd_src && (code == SRC_TX_READY);
    wire src_rd_xs = rd_src && (code == SRC_XOFF_SPECIAL);

    // tx ready on fall below trigger after a reload above it, or on empty
    wire tx_empty_now = (TX_COUNT_IN == '0) && (tx_count_d_ff != '0);
    wire tx_fall = tx_above_ff && (TX_COUNT_IN < trig);
    wire tx_set = fifo_en_ff ? (tx_fall || tx_empty_now) : tx_empty_now;
    wire rts_rise = RTS_IN && !rts_d_ff && mask_ff[MASK_RTS];
    wire cts_rise = CTS_IN && !cts_d_ff && mask_ff[MASK_CTS];

    // fifo status bits then the reported code
    wire [7:0] src_value = {fifo_en_ff ? FIFO_ON_BITS : 2'h0, code};
    wire [7:0] nxt_rd = rd_src ? src_value : (rd_mask ? mask_ff : 8'h00);

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            mask_ff <= INT_MASK_RESET;
            fifo_en_ff <= 1'b0;
            dma_ff <= 1'b0;
            trig_sel_ff <= 2'h0;
            RX_FIFO_RESET_OUT <= 1'b0;
            TX_FIFO_RESET_OUT <= 1'b0;
            RD_DATA_OUT <= 8'h00;
        end else if (CE_IN) begin
            if (wr_mask) begin
                mask_ff <= nxt_mask;
            end
            if (wr_fctl) begin
                fifo_en_ff <= WR_DATA_IN[FC_ENABLE];
            end
            if (fc_take) begin
                dma_ff <= WR_DATA_IN[FC_DMA];
                trig_sel_ff <= nxt_trig_sel;
            end
            RX_FIFO_RESET_OUT <= fc_take && WR_DATA_IN[FC_RX_RESET];
            TX_FIFO_RESET_OUT <= fc_take && WR_DATA_IN[FC_TX_RESET];
            if (RD_STROBE_IN) begin
                RD_DATA_OUT <= nxt_rd;
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky flags: a set in the clearing cycle wins
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            tx_flag_ff <= 1'b0;
            tx_above_ff <= 1'b0;
            tx_count_d_ff <= '0;
            timeout_flag_ff <= 1'b0;
            xoff_flag_ff <= 1'b0;
            special_flag_ff <= 1'b0;
            cts_flag_ff <= 1'b0;
            rts_flag_ff <= 1'b0;
            cts_d_ff <= 1'b0;
            rts_d_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else if (CE_IN) begin
            tx_count_d_ff <= TX_COUNT_IN;
            cts_d_ff <= CTS_IN;
            rts_d_ff <= RTS_IN;
            // remembers whether the last reload went past the trigger
            if (TX_COUNT_IN > trig) begin
                tx_above_ff <= 1'b1;
            end else if (tx_fall || TX_COUNT_IN == '0) begin
                tx_above_ff <= 1'b0;
            end
            tx_flag_ff <= tx_set || (tx_flag_ff && !src_rd_tx && !wr_data);
            // timeout flag cleared by data read
            timeout_flag_ff <= to_expire || (timeout_flag_ff && !rd_data);
            xoff_flag_ff <= XOFF_MATCH_IN || (xoff_flag_ff && !src_rd_xs && !XON_MATCH_IN);
            special_flag_ff <= SPECIAL_MATCH_IN ||
                               (special_flag_ff && !src_rd_xs && !RX_CHAR_IN);
            // pin flags cleared by modem status read
            cts_flag_ff <= cts_rise || (cts_flag_ff && !rd_modem);
            rts_flag_ff <= rts_rise || (rts_flag_ff && !rd_modem);
            wake_ff <= SLEEP_EXIT_IN || (wake_ff && !rd_src);
        end
    end

    // ----------------------------------------------------------------
    // pin-facing outputs
    // ----------------------------------------------------------------
    // wake-up shares the idle code, so it raises the line but not the code
    wire rx_req = (dma_ff && fifo_en_ff) ? (rx_level || timeout_flag_ff) : (RX_COUNT_IN != '0);
    wire tx_req = (dma_ff && fifo_en_ff) ? (TX_COUNT_IN < COUNT_W'(DEPTH)) :
                  (TX_COUNT_IN == '0);
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            INT_OUT <= 1'b0;
            FIFO_EN_OUT <= 1'b0;
            DMA_MODE_OUT <= 1'b0;
            TRIG_LEVEL_OUT <= TRIG_LVL_0;
            SLEEP_EN_OUT <= 1'b0;
            RX_DMA_REQUEST_N_OUT <= 1'b1;
            TX_DMA_REQUEST_N_OUT <= 1'b1;
        end else if (CE_IN) begin
            // interrupt line tracks the pending state
            INT_OUT <= any_pend || wake_ff;
            // fifo control pins show a write one cycle on, in step with the register
            FIFO_EN_OUT <= wr_fctl ? WR_DATA_IN[FC_ENABLE] : fifo_en_ff;
            DMA_MODE_OUT <= fc_take ? WR_DATA_IN[FC_DMA] : dma_ff;
            TRIG_LEVEL_OUT <= fc_take ? trig_level(nxt_trig_sel) : trig;
            SLEEP_EN_OUT <= ENH_ENABLE_IN && mask_ff[MASK_ENH_LO];
            // ready pins follow the selected mode
            RX_DMA_REQUEST_N_OUT <= !rx_req;
            TX_DMA_REQUEST_N_OUT <= !tx_req;
        end
    end
endmodule // uart_interrupt_fifo_control
`default_nettype wire

// file: tb/ifc_props.sv
// concurrent checks on the interrupt and fifo control ports
`timescale 1ns/1ps
`default_nettype none
module ifc_props
    import uart_int_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic CE_IN,
    input wire logic [2:0] ADDR_IN,
    input wire logic RD_STROBE_IN,
    input wire logic WR_STROBE_IN,
    input wire logic [7:0] WR_DATA_IN,
    input wire logic ENH_ENABLE_IN,
    input wire logic [7:0] RD_DATA_OUT,
    input wire logic INT_OUT,
    input wire logic FIFO_EN_OUT,
    input wire logic RX_FIFO_RESET_OUT,
    input wire logic TX_FIFO_RESET_OUT,
    input wire logic DMA_MODE_OUT,
    input wire logic [4:0] TRIG_LEVEL_OUT
);
    // ------------------------------------------------
    // decoded bus events
    // ------------------------------------------------
    wire logic wr_any = CE_IN && WR_STROBE_IN && ADDR_IN == ADDR_SRC_FCTL;
    wire logic wr_fc = wr_any && WR_DATA_IN[FC_ENABLE];
    wire logic rd_src = CE_IN && RD_STROBE_IN && ADDR_IN == ADDR_SRC_FCTL;
    wire logic rd_dead = CE_IN && RD_STROBE_IN && ADDR_IN != ADDR_SRC_FCTL
        && ADDR_IN != ADDR_INT_MASK;
    // one shared select: enhanced writes carry it in 5:4, plain writes in 7:6
    wire logic [1:0] sel = ENH_ENABLE_IN ? WR_DATA_IN[5:4] : WR_DATA_IN[7:6];
    wire logic [4:0] lvl = (sel == 2'h0) ? TRIG_LVL_0 : (sel == 2'h1) ? TRIG_LVL_1
        : (sel == 2'h2) ? TRIG_LVL_2 : TRIG_LVL_3;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_fifo_enable: assert property (wr_any |=> FIFO_EN_OUT == $past(WR_DATA_IN[FC_ENABLE]))
        else $error("fifo enable not taken from write");
    a_fifo_hold: assert property (CE_IN && !wr_any |=> $stable(FIFO_EN_OUT))
        else $error("fifo enable moved without write");
    a_rx_reset_pulse: assert property (CE_IN |=> RX_FIFO_RESET_OUT ==
        $past(wr_fc && WR_DATA_IN[FC_RX_RESET])) else $error("rx pointer reset pulse wrong");
    a_tx_reset_pulse: assert property (CE_IN |=> TX_FIFO_RESET_OUT ==
        $past(wr_fc && WR_DATA_IN[FC_TX_RESET])) else $error("tx pointer reset pulse wrong");
    a_dma_select: assert property (wr_fc |=> DMA_MODE_OUT == $past(WR_DATA_IN[FC_DMA]))
        else $error("dma mode not taken from write");
    a_dma_refused: assert property (wr_any && !WR_DATA_IN[FC_ENABLE] |=> $stable(DMA_MODE_OUT))
        else $error("dma mode changed by refused write");
    a_trig_select: assert property (wr_fc |=> TRIG_LEVEL_OUT == $past(lvl))
        else $error("trigger level wrong after write");
    a_src_fifo_bits: assert property (rd_src |=>
        RD_DATA_OUT[7:6] == ($past(FIFO_EN_OUT) ? FIFO_ON_BITS : 2'h0))
        else $error("source bits 7:6 disagree with fifo enable");
    a_rd_hold: assert property (CE_IN && !RD_STROBE_IN |=> $stable(RD_DATA_OUT))
        else $error("read data moved without read");
    a_dead_read: assert property (rd_dead |=> RD_DATA_OUT == 8'h00)
        else $error("outside register read not zero");
    c_timeout_read: cover property (rd_src ##1 RD_DATA_OUT[5:0] == SRC_TIMEOUT);
    c_both_reset: cover property (wr_fc && WR_DATA_IN[FC_RX_RESET] && WR_DATA_IN[FC_TX_RESET]);
    c_int_served: cover property ($rose(INT_OUT) ##[1:20] rd_src);
endmodule // ifc_props

bind uart_interrupt_fifo_control ifc_props u_props (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .CE_IN(CE_IN), .ADDR_IN(ADDR_IN),
    .RD_STROBE_IN(RD_STROBE_IN), .WR_STROBE_IN(WR_STROBE_IN), .WR_DATA_IN(WR_DATA_IN),
    .ENH_ENABLE_IN(ENH_ENABLE_IN), .RD_DATA_OUT(RD_DATA_OUT), .INT_OUT(INT_OUT),
    .FIFO_EN_OUT(FIFO_EN_OUT), .RX_FIFO_RESET_OUT(RX_FIFO_RESET_OUT),
    .TX_FIFO_RESET_OUT(TX_FIFO_RESET_OUT), .DMA_MODE_OUT(DMA_MODE_OUT),
    .TRIG_LEVEL_OUT(TRIG_LEVEL_OUT)
);
`default_nettype wire

// file: tb/host_bus_model.sv
// host processor side of the parallel register bus
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    output logic [2:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [7:0] data_out
);
    // ------------------------------------------------
    // single byte bus cycles
    // ------------------------------------------------
    initial {addr_out, rd_out, wr_out, data_out} = 13'h0000;
    // enable bit travels in the same byte
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {addr_out, data_out, wr_out} <= {a, d, 1'b1};
        @(posedge clk_in);
        {data_out, wr_out} <= {~d, 1'b0};
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        {addr_out, rd_out} <= {a, 1'b1};
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(posedge clk_in);
        #1 d = rd_data_in;
    endtask
endmodule // host_bus_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking testbench for the interrupt and fifo control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import uart_int_pkg::*;
    // ------------------------------------------------
    // signals and instances
    // ------------------------------------------------
    logic clk, rst, enh, rx_char, tick, xoff, xon, spec, cts, rts, wake, fon;
    logic [4:1] line;
    logic [3:0] modem, cbits;
    logic [4:0] rxc, txc, trig;
    logic [7:0] rdat, v;
    logic int_o, fen, rxr, txr, dma, rxq, txq, slp;
    wire [2:0] addr;
    wire rd_stb, wr_stb;
    wire [7:0] wdat;
    int num_errors, total_checks;
    host_bus_model host (.clk_in(clk), .rd_data_in(rdat), .addr_out(addr), .rd_out(rd_stb),
        .wr_out(wr_stb), .data_out(wdat));
    uart_interrupt_fifo_control #(.DEPTH(FIFO_DEPTH)) uut (.CLK_IN(clk), .RESET_IN(rst),
        .CE_IN(1'b1), .ADDR_IN(addr), .RD_STROBE_IN(rd_stb), .WR_STROBE_IN(wr_stb),
        .WR_DATA_IN(wdat), .ENH_ENABLE_IN(enh), .LINE_STATUS_IN(line), .MODEM_STATUS_IN(modem),
        .RX_COUNT_IN(rxc), .TX_COUNT_IN(txc), .RX_CHAR_IN(rx_char), .BIT_TICK_IN(tick),
        .CHAR_BITS_IN(cbits), .XOFF_MATCH_IN(xoff), .XON_MATCH_IN(xon),
        .SPECIAL_MATCH_IN(spec), .CTS_IN(cts), .RTS_IN(rts), .SLEEP_EXIT_IN(wake),
        .RD_DATA_OUT(rdat), .INT_OUT(int_o), .FIFO_EN_OUT(fen), .RX_FIFO_RESET_OUT(rxr),
        .TX_FIFO_RESET_OUT(txr), .DMA_MODE_OUT(dma), .TRIG_LEVEL_OUT(trig),
        .SLEEP_EN_OUT(slp), .RX_DMA_REQUEST_N_OUT(rxq), .TX_DMA_REQUEST_N_OUT(txq));
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] s(input logic [5:0] c);
        s = {fon ? FIFO_ON_BITS : 2'h0, c};
    endfunction
    task automatic src(input logic [5:0] c);
        host.rd(ADDR_SRC_FCTL, v);
        chk(v, s(c));
    endtask
    // int output lags its flag by a cycle, so let one edge pass first
    task automatic pin_int(input logic e);
        @(posedge clk);
        @(negedge clk);
        chk({7'h0, int_o}, {7'h0, e});
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset;
        src(SRC_NONE);
        chk({3'h0, trig}, {3'h0, TRIG_LVL_0});
        chk({7'h0, dma}, 8'h00);
        host.rd(ADDR_INT_MASK, v);
        chk(v, INT_MASK_RESET);
        host.rd(3'h7, v);
        chk(v, 8'h00);
    endtask
    task automatic t_fctl;
        logic [4:0] lv [4];
        lv = '{TRIG_LVL_0, TRIG_LVL_1, TRIG_LVL_2, TRIG_LVL_3};
        host.wr(ADDR_SRC_FCTL, 8'h07);
        @(negedge clk);
        chk({6'h0, rxr, txr}, 8'h03);
        @(negedge clk);
        chk({5'h0, fen, rxr, txr}, 8'h04);
        host.wr(ADDR_SRC_FCTL, 8'h09);
        host.wr(ADDR_SRC_FCTL, 8'h0E);
        @(negedge clk);
        chk({5'h0, fen, dma, rxr}, 8'h02);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) enh <= i[2];
            host.wr(ADDR_SRC_FCTL, i[2] ? {2'h0, i[1:0], 4'h1} : {i[1:0], 6'h01});
            @(negedge clk);
            chk({3'h0, trig}, {3'h0, lv[i[1:0]]});
        end
        host.wr(ADDR_SRC_FCTL, 8'h40);
        @(negedge clk);
        chk({3'h0, trig}, {3'h0, TRIG_LVL_3});
    endtask
    task automatic t_prio;
        host.wr(ADDR_SRC_FCTL, 8'h01);
        fon = 1;
        host.wr(ADDR_INT_MASK, 8'h0F);
        @(posedge clk) {line, modem, rxc} <= {4'h2, 4'h1, 5'h01};
        src(SRC_LINE);
        pin_int(1'b1);
        chk({6'h0, rxq, txq}, 8'h01);
        @(posedge clk) line <= 4'h0;
        host.rd(ADDR_LINE_STATUS, v);
        src(SRC_RX_DATA);
        @(posedge clk) {rxc, txc} <= 10'h000;
        src(SRC_TX_READY);
        src(SRC_MODEM);
        @(posedge clk) txc <= 5'h05;
        @(posedge clk) txc <= 5'h00;
        host.wr(ADDR_DATA, 8'h55);
        src(SRC_MODEM);
        @(posedge clk) modem <= 4'h0;
        host.rd(ADDR_MODEM_STATUS, v);
        src(SRC_NONE);
        pin_int(1'b0);
    endtask
    task automatic t_tmo;
        int lim;
        lim = 4 * cbits + 12;
        @(posedge clk) {enh, txc} <= {1'b1, 5'h0F};
        host.wr(ADDR_SRC_FCTL, 8'h39);
        @(posedge clk) rxc <= 5'h02;
        for (int i = 0; i < lim + 2; i++) begin
            if (i == lim - 2) pin_int(1'b0);
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
        pin_int(1'b1);
        chk({6'h0, rxq, txq}, 8'h00);
        src(SRC_TIMEOUT);
        host.rd(ADDR_DATA, v);
        src(SRC_NONE);
    endtask
    task automatic t_enh;
        @(posedge clk) rxc <= 5'h00;
        host.wr(ADDR_INT_MASK, 8'hF0);
        @(posedge clk) xoff <= 1'b1;
        @(posedge clk) xoff <= 1'b0;
        src(SRC_XOFF_SPECIAL);
        chk({7'h0, slp}, 8'h01);
        src(SRC_NONE);
        @(posedge clk) spec <= 1'b1;
        @(posedge clk) spec <= 1'b0;
        pin_int(1'b1);
        @(posedge clk) rx_char <= 1'b1;
        @(posedge clk) rx_char <= 1'b0;
        src(SRC_NONE);
        @(posedge clk) xoff <= 1'b1;
        @(posedge clk) xoff <= 1'b0;
        pin_int(1'b1);
        @(posedge clk) xon <= 1'b1;
        @(posedge clk) xon <= 1'b0;
        src(SRC_NONE);
        @(posedge clk) cts <= 1'b1;
        repeat (2) @(posedge clk);
        src(SRC_FLOW_PIN);
        host.rd(ADDR_MODEM_STATUS, v);
        src(SRC_NONE);
        @(posedge clk) rts <= 1'b1;
        repeat (2) @(posedge clk);
        src(SRC_FLOW_PIN);
        host.rd(ADDR_MODEM_STATUS, v);
        src(SRC_NONE);
        host.wr(ADDR_INT_MASK, 8'hC0);
        @(posedge clk) enh <= 1'b0;
        host.wr(ADDR_INT_MASK, 8'h20);
        @(posedge clk) {enh, xoff} <= 2'h3;
        @(posedge clk) xoff <= 1'b0;
        src(SRC_NONE);
        host.rd(ADDR_INT_MASK, v);
        chk(v, 8'hC0);
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        pin_int(1'b1);
        src(SRC_NONE);
        pin_int(1'b0);
    endtask
    // ------------------------------------------------
    // clock, sequence, watchdog and verdict
    // ------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst, enh, rx_char, tick, xoff, xon, spec, cts, rts, wake, fon} = 11'h400;
        {line, modem, cbits, rxc, txc} = 22'h00_2805;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fctl();
        t_prio();
        t_tmo();
        t_enh();
        report_and_stop();
    end
    // the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
